// File: rtl/prc_consts.svh
// offsets, field positions, reset values of the serial-port register block
`ifndef PRC_CONSTS_SVH
`define PRC_CONSTS_SVH

// ------------------------------------------------------------
// address map
// ------------------------------------------------------------
`define PRC_RGN_LG 14
`define PRC_INTC_RGN_LG 12
`define PRC_BASE0 32'hfffc_0000
`define PRC_BASE1 32'hfffc_4000

// ------------------------------------------------------------
// register offsets inside a port region
// ------------------------------------------------------------
`define PRC_OFF_CR 14'h0000
`define PRC_OFF_MR 14'h0004
`define PRC_OFF_IER 14'h0008
`define PRC_OFF_IDR 14'h000c
`define PRC_OFF_IMR 14'h0010
`define PRC_OFF_SR 14'h0014
`define PRC_OFF_CHER 14'h0018
`define PRC_OFF_CHDR 14'h001c
`define PRC_OFF_CHSR 14'h0020
`define PRC_OFF_RPTR 14'h0030
`define PRC_OFF_RCNT 14'h0034
`define PRC_OFF_TPTR 14'h0038
`define PRC_OFF_TCNT 14'h003c

// ------------------------------------------------------------
// fields and reset values
// ------------------------------------------------------------
`define PRC_CR_CLR_ENDRX 0
`define PRC_CR_CLR_ENDTX 1
`define PRC_MR_AUTODIS 0
`define PRC_MR_FIXADR 1
`define PRC_SR_ENDRX 0
`define PRC_SR_ENDTX 1
`define PRC_SR_RXPEND 2
`define PRC_CH_RX 0
`define PRC_CH_TX 1
`define PRC_MR_RST 2'h0
`define PRC_IMR_RST 3'h0
`define PRC_CHSR_RST 2'h0
`define PRC_PTR_RST 32'h0000_0000
`define PRC_CNT_RST 16'h0000
`define PRC_XFER_SIZE 32'h0000_0001

`endif

// File: rtl/prc_pkg.sv
// types shared by the serial-port register block
package prc_pkg;
   typedef enum {CH_IDLE, CH_MEM, CH_OUT} prc_ch_state_t;
   typedef logic [7:0] prc_byte_t;
   typedef logic [31:0] prc_word_t;
   typedef logic [15:0] prc_cnt_t;
endpackage

// File: rtl/prc_buf.sv
// two-entry byte buffer with valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none
module prc_buf
   import prc_pkg::*;
(
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // filling side
   input wire logic i_valid,
   input wire prc_byte_t i_data,
   output logic o_ready,
   // draining side
   output logic o_valid,
   output prc_byte_t o_data,
   input wire logic i_ready
);
   prc_byte_t mem_r [2];
   prc_byte_t mem_nxt [2];
   logic wp_r, wp_nxt, rp_r, rp_nxt;
   logic [1:0] cnt_r, cnt_nxt;
   logic push, pop;

   assign o_ready = cnt_r != 2'h2;
   assign o_valid = cnt_r != 2'h0;
   assign o_data = mem_r[rp_r];
   assign push = i_valid && o_ready;
   assign pop = o_valid && i_ready;

   always_comb begin
      mem_nxt = mem_r;
      wp_nxt = wp_r;
      rp_nxt = rp_r;
      cnt_nxt = cnt_r;
      if (push) begin
         mem_nxt[wp_r] = i_data;
         wp_nxt = ~wp_r;
      end
      if (pop) begin
         rp_nxt = ~rp_r;
      end
      if (push && !pop) begin
         cnt_nxt = cnt_r + 2'h1;
      end else if (pop && !push) begin
         cnt_nxt = cnt_r - 2'h1;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         mem_r[0] <= 8'h00;
         mem_r[1] <= 8'h00;
         wp_r <= 1'b0;
         rp_r <= 1'b0;
         cnt_r <= 2'h0;
      end else begin
         mem_r <= mem_nxt;
         wp_r <= wp_nxt;
         rp_r <= rp_nxt;
         cnt_r <= cnt_nxt;
      end
   end
endmodule
`default_nettype wire

// File: rtl/prc_chan.sv
// one data-controller channel: pointer, count, byte mover
`include "prc_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module prc_chan
   import prc_pkg::*;
#(
   parameter bit IS_TX = 1'b0
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // register side
   input wire logic i_en,
   input wire logic i_fix,
   input wire logic i_ld_ptr,
   input wire logic i_ld_cnt,
   input wire prc_word_t i_wdata,
   output prc_word_t o_ptr,
   output prc_cnt_t o_cnt,
   output logic o_end,
   // memory side
   output logic o_req,
   output prc_word_t o_addr,
   output prc_byte_t o_wdata,
   input wire logic i_ack,
   input wire prc_byte_t i_rdata,
   // receive stream in
   input wire logic i_dat_valid,
   input wire prc_byte_t i_dat,
   output logic o_dat_ready,
   // transmit stream out
   output logic o_dat_valid,
   output prc_byte_t o_dat,
   input wire logic i_dat_ready
);
   prc_ch_state_t state_r, state_nxt;
   prc_word_t ptr_r, ptr_nxt;
   prc_cnt_t cnt_r, cnt_nxt;
   prc_byte_t dat_r, dat_nxt;
   logic end_r, end_nxt;
   logic active;

   assign active = i_en && cnt_r != 16'h0000;
   assign o_ptr = ptr_r;
   assign o_cnt = cnt_r;
   assign o_end = end_r;
   assign o_req = state_r == CH_MEM;
   assign o_addr = ptr_r;
   assign o_wdata = dat_r;
   assign o_dat = dat_r;
   assign o_dat_valid = state_r == CH_OUT;
   // rx byte is taken from the buffer as the memory write starts
   assign o_dat_ready = !IS_TX && state_r == CH_IDLE && active;

   always_comb begin
      state_nxt = state_r;
      ptr_nxt = ptr_r;
      cnt_nxt = cnt_r;
      dat_nxt = dat_r;
      end_nxt = 1'b0;
      unique case (state_r)
         CH_IDLE: begin
            if (active && (IS_TX || i_dat_valid)) begin
               state_nxt = CH_MEM;
               if (!IS_TX) begin
                  dat_nxt = i_dat;
               end
            end
         end
         CH_MEM: begin
            if (i_ack) begin
               ptr_nxt = i_fix ? ptr_r : ptr_r + `PRC_XFER_SIZE;
               cnt_nxt = cnt_r - 16'h0001;
               end_nxt = cnt_r == 16'h0001;
               if (IS_TX) begin
                  dat_nxt = i_rdata;
                  state_nxt = CH_OUT;
               end else begin
                  state_nxt = CH_IDLE;
               end
            end
         end
         CH_OUT: begin
            if (i_dat_ready) begin
               state_nxt = CH_IDLE;
            end
         end
      endcase
      // software load wins over a transfer update in the same cycle
      if (i_ld_ptr) begin
         ptr_nxt = i_wdata;
      end
      if (i_ld_cnt) begin
         cnt_nxt = i_wdata[15:0];
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         state_r <= CH_IDLE;
         ptr_r <= `PRC_PTR_RST;
         cnt_r <= `PRC_CNT_RST;
         dat_r <= 8'h00;
         end_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         ptr_r <= ptr_nxt;
         cnt_r <= cnt_nxt;
         dat_r <= dat_nxt;
         end_r <= end_nxt;
      end
   end
endmodule
`default_nettype wire

// File: rtl/prc_top.sv
// register block of two serial ports with four data channels
`include "prc_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module prc_top
   import prc_pkg::*;
(
   // clock and reset
   input wire logic I_CLK_SYS,
   input wire logic I_RESET,
   // peripheral bus
   input wire logic I_PSEL,
   input wire logic I_PENABLE,
   input wire logic I_PWRITE,
   input wire logic [31:0] I_PADDR,
   input wire logic [31:0] I_PWDATA,
   output logic [31:0] O_PRDATA,
   // receive streams from the serial ports
   input wire logic [1:0] I_RX_VALID,
   input wire logic [15:0] I_RX_DATA,
   output logic [1:0] O_RX_READY,
   // transmit streams to the serial ports
   output logic [1:0] O_TX_VALID,
   output logic [15:0] O_TX_DATA,
   input wire logic [1:0] I_TX_READY,
   // memory port
   output logic O_MEM_REQ,
   output logic O_MEM_WE,
   output logic [31:0] O_MEM_ADDR,
   output logic [7:0] O_MEM_WDATA,
   input wire logic I_MEM_ACK,
   input wire logic [7:0] I_MEM_RDATA,
   // interrupt sources, one per port
   output logic [1:0] O_IRQ
);

   // ------------------------------------------------------------
   // decoding
   // ------------------------------------------------------------
   function automatic logic in_rgn(input logic [31:0] a,
                                   input logic [31:0] base);
      return a[31:`PRC_RGN_LG] == base[31:`PRC_RGN_LG];
   endfunction

   logic [13:0] off;
   logic [1:0] hit;
   logic wr_en, rd_setup;
   logic [1:0] wr_p;

   // byte lanes do not exist here: the low two bits never reach decode
   assign off = {I_PADDR[13:2], 2'b00};
   assign hit[0] = in_rgn(I_PADDR, `PRC_BASE0);
   assign hit[1] = in_rgn(I_PADDR, `PRC_BASE1);
   assign wr_en = I_PSEL && I_PENABLE && I_PWRITE;
   assign rd_setup = I_PSEL && !I_PENABLE && !I_PWRITE;
   assign wr_p = {2{wr_en}} & hit;

   // ------------------------------------------------------------
   // channel wiring
   // ------------------------------------------------------------
   prc_word_t ch_ptr [4];
   prc_cnt_t ch_cnt [4];
   prc_word_t ch_addr [4];
   prc_byte_t ch_wdata [4];
   logic [3:0] ch_end, ch_req, ch_ack, ld_ptr, ld_cnt, ch_en, ch_fix;
   logic [1:0] rx_pend;

   // ------------------------------------------------------------
   // per-port register state
   // ------------------------------------------------------------
   logic [1:0][1:0] mr_r, mr_nxt;
   logic [1:0][2:0] imr_r, imr_nxt;
   logic [1:0][1:0] chsr_r, chsr_nxt;
   logic [1:0][1:0] sta_r, sta_nxt;
   logic [1:0][2:0] sr_view;

   always_comb begin
      mr_nxt = mr_r;
      imr_nxt = imr_r;
      chsr_nxt = chsr_r;
      sta_nxt = sta_r;
      ld_ptr = 4'h0;
      ld_cnt = 4'h0;
      for (int p = 0; p < 2; p++) begin
         // auto-disable first so an enable write in the same cycle wins
         for (int d = 0; d < 2; d++) begin
            if (mr_r[p][`PRC_MR_AUTODIS] && ch_end[2*p+d]) begin
               chsr_nxt[p][d] = 1'b0;
            end
         end
         if (wr_p[p]) begin
            case (off)
               `PRC_OFF_CR: begin
                  if (I_PWDATA[`PRC_CR_CLR_ENDRX]) begin
                     sta_nxt[p][`PRC_SR_ENDRX] = 1'b0;
                  end
                  if (I_PWDATA[`PRC_CR_CLR_ENDTX]) begin
                     sta_nxt[p][`PRC_SR_ENDTX] = 1'b0;
                  end
               end
               `PRC_OFF_MR: begin
                  mr_nxt[p] = I_PWDATA[1:0];
               end
               `PRC_OFF_IER: begin
                  imr_nxt[p] = imr_r[p] | I_PWDATA[2:0];
               end
               `PRC_OFF_IDR: begin
                  imr_nxt[p] = imr_r[p] & ~I_PWDATA[2:0];
               end
               `PRC_OFF_CHER: begin
                  chsr_nxt[p] = chsr_nxt[p] | I_PWDATA[1:0];
               end
               `PRC_OFF_CHDR: begin
                  chsr_nxt[p] = chsr_nxt[p] & ~I_PWDATA[1:0];
               end
               `PRC_OFF_RPTR: begin
                  ld_ptr[2*p+`PRC_CH_RX] = 1'b1;
               end
               `PRC_OFF_RCNT: begin
                  ld_cnt[2*p+`PRC_CH_RX] = 1'b1;
               end
               `PRC_OFF_TPTR: begin
                  ld_ptr[2*p+`PRC_CH_TX] = 1'b1;
               end
               `PRC_OFF_TCNT: begin
                  ld_cnt[2*p+`PRC_CH_TX] = 1'b1;
               end
               // status and mask views ignore writes
               default: begin
               end
            endcase
         end
         // a channel end in the clearing cycle still lands
         if (ch_end[2*p+`PRC_CH_RX]) begin
            sta_nxt[p][`PRC_SR_ENDRX] = 1'b1;
         end
         if (ch_end[2*p+`PRC_CH_TX]) begin
            sta_nxt[p][`PRC_SR_ENDTX] = 1'b1;
         end
      end
   end

   always_ff @(posedge I_CLK_SYS) begin
      if (I_RESET) begin
         mr_r <= {2{`PRC_MR_RST}};
         imr_r <= {2{`PRC_IMR_RST}};
         chsr_r <= {2{`PRC_CHSR_RST}};
         sta_r <= 4'h0;
      end else begin
         mr_r <= mr_nxt;
         imr_r <= imr_nxt;
         chsr_r <= chsr_nxt;
         sta_r <= sta_nxt;
      end
   end

   // ------------------------------------------------------------
   // status view and interrupt sources
   // ------------------------------------------------------------
   always_comb begin
      for (int p = 0; p < 2; p++) begin
         sr_view[p] = {rx_pend[p], sta_r[p]};
         O_IRQ[p] = |(sr_view[p] & imr_r[p]);
         ch_en[2*p] = chsr_r[p][`PRC_CH_RX];
         ch_en[2*p+1] = chsr_r[p][`PRC_CH_TX];
         ch_fix[2*p] = mr_r[p][`PRC_MR_FIXADR];
         ch_fix[2*p+1] = mr_r[p][`PRC_MR_FIXADR];
      end
   end

   // ------------------------------------------------------------
   // read data, captured in the setup phase
   // ------------------------------------------------------------
   logic [31:0] prdata_r, prdata_nxt;
   logic ps;

   assign ps = hit[1];
   assign O_PRDATA = prdata_r;

   always_comb begin
      prdata_nxt = 32'h0000_0000;
      if (rd_setup && |hit) begin
         case (off)
            `PRC_OFF_MR: prdata_nxt = {30'h0, mr_r[ps]};
            `PRC_OFF_IMR: prdata_nxt = {29'h0, imr_r[ps]};
            `PRC_OFF_SR: prdata_nxt = {29'h0, sr_view[ps]};
            `PRC_OFF_CHSR: prdata_nxt = {30'h0, chsr_r[ps]};
            `PRC_OFF_RPTR: prdata_nxt = ch_ptr[{ps, 1'b0}];
            `PRC_OFF_RCNT: prdata_nxt = {16'h0, ch_cnt[{ps, 1'b0}]};
            `PRC_OFF_TPTR: prdata_nxt = ch_ptr[{ps, 1'b1}];
            `PRC_OFF_TCNT: prdata_nxt = {16'h0, ch_cnt[{ps, 1'b1}]};
            // control and command registers read back as zero
            default: prdata_nxt = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge I_CLK_SYS) begin
      if (I_RESET) begin
         prdata_r <= 32'h0000_0000;
      end else begin
         prdata_r <= prdata_nxt;
      end
   end

   // ------------------------------------------------------------
   // memory port arbiter
   // ------------------------------------------------------------
   // fixed priority, lowest channel first; a grant is held until the
   // ack so a stalled memory cannot tear a transfer
   logic [1:0] own_r, own_nxt;
   logic busy_r, busy_nxt;

   always_comb begin
      own_nxt = own_r;
      busy_nxt = busy_r;
      if (!busy_r) begin
         for (int c = 3; c >= 0; c--) begin
            if (ch_req[c]) begin
               own_nxt = 2'(c);
               busy_nxt = 1'b1;
            end
         end
      end else if (I_MEM_ACK) begin
         busy_nxt = 1'b0;
      end
   end

   always_ff @(posedge I_CLK_SYS) begin
      if (I_RESET) begin
         own_r <= 2'h0;
         busy_r <= 1'b0;
      end else begin
         own_r <= own_nxt;
         busy_r <= busy_nxt;
      end
   end

   assign O_MEM_REQ = busy_r && ch_req[own_r];
   assign O_MEM_WE = own_r[0] == 1'(`PRC_CH_RX);
   assign O_MEM_ADDR = ch_addr[own_r];
   assign O_MEM_WDATA = ch_wdata[own_r];

   // ------------------------------------------------------------
   // channels and their buffers
   // ------------------------------------------------------------
   genvar c;
   generate
      for (c = 0; c < 4; c++) begin : g_ch
         logic b_valid, b_ready;
         prc_byte_t b_data;
         assign ch_ack[c] = I_MEM_ACK && busy_r && own_r == 2'(c);
         if (c % 2 == `PRC_CH_RX) begin : g_rx
            prc_buf u_buf (
               .i_clk(I_CLK_SYS),
               .i_rst(I_RESET),
               .i_valid(I_RX_VALID[c/2]),
               .i_data(I_RX_DATA[8*(c/2) +: 8]),
               .o_ready(O_RX_READY[c/2]),
               .o_valid(b_valid),
               .o_data(b_data),
               .i_ready(b_ready)
            );
            assign rx_pend[c/2] = b_valid;
            prc_chan #(.IS_TX(1'b0)) u_chan (
               .i_clk(I_CLK_SYS),
               .i_rst(I_RESET),
               .i_en(ch_en[c]),
               .i_fix(ch_fix[c]),
               .i_ld_ptr(ld_ptr[c]),
               .i_ld_cnt(ld_cnt[c]),
               .i_wdata(I_PWDATA),
               .o_ptr(ch_ptr[c]),
               .o_cnt(ch_cnt[c]),
               .o_end(ch_end[c]),
               .o_req(ch_req[c]),
               .o_addr(ch_addr[c]),
               .o_wdata(ch_wdata[c]),
               .i_ack(ch_ack[c]),
               .i_rdata(I_MEM_RDATA),
               .i_dat_valid(b_valid),
               .i_dat(b_data),
               .o_dat_ready(b_ready),
               .o_dat_valid(),
               .o_dat(),
               .i_dat_ready(1'b0)
            );
         end else begin : g_tx
            prc_chan #(.IS_TX(1'b1)) u_chan (
               .i_clk(I_CLK_SYS),
               .i_rst(I_RESET),
               .i_en(ch_en[c]),
               .i_fix(ch_fix[c]),
               .i_ld_ptr(ld_ptr[c]),
               .i_ld_cnt(ld_cnt[c]),
               .i_wdata(I_PWDATA),
               .o_ptr(ch_ptr[c]),
               .o_cnt(ch_cnt[c]),
               .o_end(ch_end[c]),
               .o_req(ch_req[c]),
               .o_addr(ch_addr[c]),
               .o_wdata(ch_wdata[c]),
               .i_ack(ch_ack[c]),
               .i_rdata(I_MEM_RDATA),
               .i_dat_valid(1'b0),
               .i_dat(8'h00),
               .o_dat_ready(),
               .o_dat_valid(b_valid),
               .o_dat(b_data),
               .i_dat_ready(b_ready)
            );
            // a stalled transmitter fills the buffer and holds the channel
            prc_buf u_buf (
               .i_clk(I_CLK_SYS),
               .i_rst(I_RESET),
               .i_valid(b_valid),
               .i_data(b_data),
               .o_ready(b_ready),
               .o_valid(O_TX_VALID[c/2]),
               .o_data(O_TX_DATA[8*(c/2) +: 8]),
               .i_ready(I_TX_READY[c/2])
            );
         end
      end
   endgenerate

endmodule
`default_nettype wire

// File: test/prc_chk.sv
// port assertions for the serial-port register block
`timescale 1ns/100ps
`default_nettype none
module prc_chk (
   // clock, reset, bus
   input wire logic I_CLK_SYS,
   input wire logic I_RESET,
   input wire logic I_PSEL,
   input wire logic I_PENABLE,
   input wire logic I_PWRITE,
   input wire logic [31:0] I_PADDR,
   input wire logic [31:0] I_PWDATA,
   input wire logic [31:0] O_PRDATA,
   // streams, memory, interrupts
   input wire logic [1:0] O_TX_VALID,
   input wire logic [15:0] O_TX_DATA,
   input wire logic [1:0] I_TX_READY,
   input wire logic O_MEM_REQ,
   input wire logic O_MEM_WE,
   input wire logic [31:0] O_MEM_ADDR,
   input wire logic I_MEM_ACK,
   input wire logic [1:0] O_IRQ
);
   default clocking cb @(posedge I_CLK_SYS); endclocking
   default disable iff (I_RESET);
   logic rd_su;
   logic wr_ac;
   assign rd_su = I_PSEL & ~I_PENABLE & ~I_PWRITE;
   assign wr_ac = I_PSEL & I_PENABLE & I_PWRITE;
   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   a_rd_region: assert property (rd_su && I_PADDR[31:15] != 17'h1fff8
      |=> O_PRDATA == 32'h0) else $error("read outside regions not zero");
   a_rd_idle: assert property (!rd_su |=> O_PRDATA == 32'h0)
      else $error("read data outside access phase");
   a_unused_zero: assert property (rd_su && I_PADDR[13:0] < 14'h0030
      |=> O_PRDATA[31:3] == 29'h0) else $error("unused bits read one");
   a_cmd_reads_zero: assert property (rd_su && I_PADDR[13:2] == 12'h0
      |=> O_PRDATA == 32'h0) else $error("control register readable");
   a_cnt_width: assert property (rd_su && I_PADDR[13:4] == 10'h3
      && I_PADDR[2] |=> O_PRDATA[31:16] == 16'h0)
      else $error("count wider than 16");
   a_mask_off: assert property (wr_ac && I_PADDR[31:14] == 18'h3fff0
      && I_PADDR[13:2] == 12'h3 && I_PWDATA[2:0] == 3'h7 |=> ##1 !O_IRQ[0])
      else $error("interrupt after full mask clear");
   a_mem_hold: assert property (O_MEM_REQ && !I_MEM_ACK |=> O_MEM_REQ
      && $stable(O_MEM_ADDR) && $stable(O_MEM_WE)) else $error("mem req moved");
   a_mem_drop: assert property (O_MEM_REQ && I_MEM_ACK |=> !O_MEM_REQ)
      else $error("mem req held after ack");
   a_tx_hold_lo: assert property (O_TX_VALID[0] && !I_TX_READY[0]
      |=> O_TX_VALID[0] && $stable(O_TX_DATA[7:0])) else $error("tx0 moved");
   a_tx_hold_hi: assert property (O_TX_VALID[1] && !I_TX_READY[1]
      |=> O_TX_VALID[1] && $stable(O_TX_DATA[15:8])) else $error("tx1 moved");
   c_mem_wr: cover property (O_MEM_REQ && O_MEM_WE && I_MEM_ACK);
   c_tx_hi: cover property (O_TX_VALID[1] && I_TX_READY[1]);
   c_irq_hi: cover property ($rose(O_IRQ[1]));
endmodule
`default_nettype wire

// File: test/prc_mem.sv
// byte memory answering the block's memory port
`timescale 1ns/100ps
`default_nettype none
module prc_mem
   import prc_pkg::*;
(
   // clock and pace: slow adds wait cycles
   input wire logic i_clk,
   input wire logic i_slow,
   // memory port
   input wire logic i_req,
   input wire logic i_we,
   input wire prc_word_t i_addr,
   input wire prc_byte_t i_wdata,
   output logic o_ack,
   output prc_byte_t o_rdata
);
   prc_byte_t mem [256];
   logic [1:0] wait_r = 2'h0;
   initial o_ack = 1'b0;
   initial o_rdata = 8'h00;
   // data scrambled outside the ack cycle so a late sample shows
   always @(posedge i_clk) begin
      o_ack <= 1'b0;
      o_rdata <= ~o_rdata;
      if (i_req && !o_ack) begin
         if (wait_r != 2'h0) begin
            wait_r <= wait_r - 2'h1;
         end else begin
            o_ack <= 1'b1;
            o_rdata <= mem[i_addr[7:0]];
            if (i_we) begin
               mem[i_addr[7:0]] <= i_wdata;
            end
            wait_r <= i_slow ? 2'h3 : 2'h0;
         end
      end
   end
endmodule
`default_nettype wire

// File: test/prc_top_tb.sv
// testbench of the serial-port register block
`timescale 1ns/100ps
`default_nettype none
`include "prc_consts.svh"
module prc_top_tb;
   logic I_CLK_SYS = 1'b0;
   logic I_RESET = 1'b1;
   logic I_PSEL = 1'b0;
   logic I_PENABLE = 1'b0;
   logic I_PWRITE = 1'b0;
   logic [31:0] I_PADDR = 32'h0;
   logic [31:0] I_PWDATA = 32'h0;
   logic [31:0] O_PRDATA, O_MEM_ADDR;
   logic [1:0] I_RX_VALID = 2'h0;
   logic [15:0] I_RX_DATA = 16'h0;
   logic [1:0] O_RX_READY, O_TX_VALID, O_IRQ;
   logic [15:0] O_TX_DATA;
   logic [1:0] I_TX_READY = 2'h0;
   logic O_MEM_REQ, O_MEM_WE, I_MEM_ACK;
   logic [7:0] O_MEM_WDATA, I_MEM_RDATA;
   logic slow = 1'b0;
   int err_total = 0;
   int check_count = 0;
   int cyc = 0;
   integer seed = 32'h89fac3c6;
   logic [31:0] exp_rd[$];
   logic [39:0] exp_mw[$];
   logic [8:0] exp_tx[$];
   logic [13:0] rst_offs [8] = '{`PRC_OFF_MR, `PRC_OFF_IMR, `PRC_OFF_SR,
      `PRC_OFF_CHSR, `PRC_OFF_RPTR, `PRC_OFF_RCNT, `PRC_OFF_TPTR,
      `PRC_OFF_TCNT};

   always #5 I_CLK_SYS = ~I_CLK_SYS;

   prc_top prc_top_i (.*);
   prc_mem prc_mem_i (.i_clk(I_CLK_SYS), .i_slow(slow), .i_req(O_MEM_REQ),
      .i_we(O_MEM_WE), .i_addr(O_MEM_ADDR), .i_wdata(O_MEM_WDATA),
      .o_ack(I_MEM_ACK), .o_rdata(I_MEM_RDATA));

   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task summarize();
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task chk(input string n, input logic [39:0] e, input logic [39:0] g);
      check_count++;
      if (g !== e) begin
         err_total++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask

   // port 2 is an address outside both regions
   function logic [31:0] ba(input int p);
      return p == 0 ? `PRC_BASE0 : p == 1 ? `PRC_BASE1 : 32'hfff8_0000;
   endfunction

   task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(negedge I_CLK_SYS);
      I_PSEL = 1'b1;
      I_PWRITE = w;
      I_PADDR = a;
      I_PWDATA = d;
      @(negedge I_CLK_SYS);
      I_PENABLE = 1'b1;
      @(negedge I_CLK_SYS);
      I_PSEL = 1'b0;
      I_PENABLE = 1'b0;
   endtask

   task wr(input int p, input logic [13:0] o, input logic [31:0] d);
      bus(1'b1, ba(p) | {18'h0, o}, d);
   endtask

   task rd(input int p, input logic [13:0] o, input logic [31:0] e);
      exp_rd.push_back(e);
      bus(1'b0, ba(p) | {18'h0, o}, 32'h0);
   endtask

   task rx_send(input int p, input logic [7:0] b);
      int n;
      logic t;
      n = 0;
      @(negedge I_CLK_SYS);
      I_RX_VALID[p] = 1'b1;
      I_RX_DATA[8*p +: 8] = b;
      do begin
         t = O_RX_READY[p];
         @(posedge I_CLK_SYS);
         if (!t) @(negedge I_CLK_SYS);
         n++;
      end while (!t && n < 200);
      @(negedge I_CLK_SYS);
      I_RX_VALID[p] = 1'b0;
      I_RX_DATA[8*p +: 8] = ~b;
   endtask

   task wt(input int p);
      int n;
      n = 0;
      while ((O_IRQ[p] !== 1'b1 || exp_tx.size() != 0
            || exp_mw.size() != 0) && n < 600) begin
         @(negedge I_CLK_SYS);
         n++;
      end
   endtask

   // ------------------------------------------------------------
   // result watcher and run limit
   // ------------------------------------------------------------
   always @(negedge I_CLK_SYS) I_TX_READY <= 2'($random(seed));

   // limit well above the few hundred cycles the tests need
   always @(posedge I_CLK_SYS) begin
      if (I_PSEL && I_PENABLE && !I_PWRITE) begin
         chk("prdata", {8'h0, exp_rd.pop_front()}, {8'h0, O_PRDATA});
      end
      if (O_MEM_REQ && O_MEM_WE && I_MEM_ACK) begin
         chk("mem_wr", exp_mw.pop_front(),
            {O_MEM_ADDR, O_MEM_WDATA});
      end
      for (int p = 0; p < 2; p++) begin
         if (O_TX_VALID[p] && I_TX_READY[p]) begin
            chk("tx", {31'h0, exp_tx.pop_front()},
               {31'h0, p[0], O_TX_DATA[8*p +: 8]});
         end
      end
      cyc++;
      if (cyc == 30000) begin
         err_total++;
         summarize();
      end
   end

   initial begin
      logic [7:0] bs [3];
      logic [31:0] a;
      repeat (5) @(posedge I_CLK_SYS);
      @(negedge I_CLK_SYS);
      I_RESET = 1'b0;
      for (int p = 0; p < 2; p++) begin
         for (int i = 0; i < 8; i++) begin
            rd(p, rst_offs[i], 32'h0);
         end
      end
      $display("test reset values done");
      wr(0, `PRC_OFF_MR, 32'hffff_ffff);
      rd(0, `PRC_OFF_MR, 32'h3);
      rd(0, 14'h0005, 32'h3);
      rd(1, `PRC_OFF_MR, 32'h0);
      rd(2, `PRC_OFF_MR, 32'h0);
      wr(0, `PRC_OFF_MR, 32'h0);
      wr(0, `PRC_OFF_SR, 32'h7);
      rd(0, `PRC_OFF_SR, 32'h0);
      rd(0, `PRC_OFF_CR, 32'h0);
      wr(0, `PRC_OFF_IMR, 32'h7);
      rd(0, `PRC_OFF_IMR, 32'h0);
      wr(0, `PRC_OFF_IER, 32'h5);
      wr(0, `PRC_OFF_IER, 32'h2);
      wr(0, `PRC_OFF_IDR, 32'h4);
      rd(0, `PRC_OFF_IMR, 32'h3);
      wr(0, `PRC_OFF_IDR, 32'h7);
      wr(0, `PRC_OFF_CHER, 32'h3);
      wr(0, `PRC_OFF_CHDR, 32'h1);
      rd(0, `PRC_OFF_CHSR, 32'h2);
      wr(0, `PRC_OFF_CHDR, 32'h2);
      rd(0, `PRC_OFF_CHSR, 32'h0);
      $display("test registers done");
      for (int p = 0; p < 2; p++) begin
         slow = p[0];
         a = p ? 32'h50 : 32'h10;
         wr(p, `PRC_OFF_RPTR, a);
         wr(p, `PRC_OFF_RCNT, 32'h3);
         wr(p, `PRC_OFF_IER, 32'h1);
         // port 1 runs with auto-disable so the end also drops the enable
         wr(p, `PRC_OFF_MR, 32'(p));
         for (int i = 0; i < 3; i++) begin
            bs[i] = 8'($random(seed));
            exp_mw.push_back({a + i, bs[i]});
         end
         rx_send(p, bs[0]);
         rx_send(p, bs[1]);
         chk("rx_ready", 40'h0, {39'h0, O_RX_READY[p]});
         wr(p, `PRC_OFF_CHER, 32'h1);
         rx_send(p, bs[2]);
         wt(p);
         chk("irq_rx", 40'h1, {39'h0, O_IRQ[p]});
         rd(p, `PRC_OFF_RPTR, a + 32'h3);
         rd(p, `PRC_OFF_RCNT, 32'h0);
         rd(p, `PRC_OFF_SR, 32'h1);
         rd(p, `PRC_OFF_CHSR, 32'(1 - p));
         wr(p, `PRC_OFF_CR, 32'h1);
         rd(p, `PRC_OFF_SR, 32'h0);
         chk("irq_clr", 40'h0, {39'h0, O_IRQ[p]});
         wr(p, `PRC_OFF_CHDR, 32'h1);
         wr(p, `PRC_OFF_IDR, 32'h7);
         $display("test receive port %0d done", p);
         a = p ? 32'hc0 : 32'h80;
         for (int i = 0; i < 3; i++) begin
            bs[i] = 8'($random(seed));
            prc_mem_i.mem[a[7:0] + i] = bs[i];
            exp_tx.push_back({p[0], bs[i]});
         end
         wr(p, `PRC_OFF_TPTR, a);
         wr(p, `PRC_OFF_TCNT, 32'h3);
         wr(p, `PRC_OFF_IER, 32'h2);
         wr(p, `PRC_OFF_CHER, 32'h2);
         wt(p);
         chk("irq_tx", 40'h1, {39'h0, O_IRQ[p]});
         rd(p, `PRC_OFF_TPTR, a + 32'h3);
         rd(p, `PRC_OFF_TCNT, 32'h0);
         rd(p, `PRC_OFF_SR, 32'h2);
         wr(p, `PRC_OFF_CR, 32'h2);
         wr(p, `PRC_OFF_IDR, 32'h7);
         wr(p, `PRC_OFF_CHDR, 32'h2);
         $display("test transmit port %0d done", p);
      end
      summarize();
   end
endmodule
bind prc_top prc_chk prc_chk_i (.*);
`default_nettype wire
